/* hw/adcr_defs.svh */
// register offsets, field positions and sizes of the host register bank
`ifndef ADCR_DEFS_SVH
`define ADCR_DEFS_SVH
`define ADCR_OFF_RESULT 5'h00
`define ADCR_OFF_TRIGGER 5'h01
`define ADCR_OFF_GAIN 5'h02
`define ADCR_OFF_RANGE 5'h06
`define ADCR_OFF_OVERSAMP 5'h07
`define ADCR_OFF_COUNTER 5'h08
`define ADCR_OFF_OUT0 5'h0c
`define ADCR_OFF_OUT1 5'h0e
`define ADCR_OFF_OUTCFG 5'h10
`define ADCR_OFF_TRIGCFG 5'h11
`define ADCR_OFF_STATUS 5'h12
`define ADCR_OFF_IRQ 5'h13
`define ADCR_OFF_PORTLO 5'h14
`define ADCR_OFF_PORTHI 5'h15
`define ADCR_OFF_SPARE 5'h16
`define ADCR_OFF_DIOCFG 5'h17
`define ADCR_OFF_NV 5'h18
`define ADCR_OFF_CALIN 5'h19
`define ADCR_OFF_CALOUT 5'h1a
`define ADCR_OFF_BRESET 5'h1b
`define ADCR_OFF_MODEL 5'h1f
`define ADCR_UNMAPPED 8'h00
`define ADCR_BIT_SCAN 2
`define ADCR_BIT_FALL 3
`define ADCR_BIT_CLKSRC 4
`define ADCR_BIT_SIMUL 0
`define ADCR_BIT_DIR_LO 0
`define ADCR_BIT_DIR_HI 1
`define ADCR_FIFO_DEPTH 1024
`define ADCR_FIFO_FULL 11'h400
`define ADCR_FIFO_HALF 11'h200
`define ADCR_BUF_FULL 2'h2
`endif

/* hw/adcr_pkg.sv */
// types shared by the register bank and its sample buffer
package adcr_pkg;
  typedef enum logic [1:0] {
    ADCR_SRC_SOFT,
    ADCR_SRC_TIMER,
    ADCR_SRC_EXT,
    ADCR_SRC_RSVD
  } adcr_src_t;
  typedef logic [15:0] adcr_sample_t;
endpackage

/* hw/adcr_stream_if.sv */
// valid/ready sample stream between the bank and its buffer
interface adcr_stream_if;
  logic valid;
  logic ready;
  adcr_pkg::adcr_sample_t data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* hw/adcr_skid_buf.sv */
// two-entry sample buffer with registered ready toward the source
`include "adcr_defs.svh"
module adcr_skid_buf (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // streams
  adcr_stream_if.snk up,
  adcr_stream_if.src dn
);
  import adcr_pkg::*;
  adcr_sample_t mem_reg [2];
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic wp_reg;
  logic rp_reg;
  logic ready_reg;
  logic push;
  logic pop;

  assign push = up.valid && ready_reg;
  assign pop = dn.valid && dn.ready;
  assign up.ready = ready_reg;
  assign dn.valid = (cnt_reg != 2'h0);
  assign dn.data = mem_reg[rp_reg];

  always_comb
  begin
    cnt_next = cnt_reg;
    if (push && !pop)
      cnt_next = cnt_reg + 2'h1;
    else if (pop && !push)
      cnt_next = cnt_reg - 2'h1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cnt_reg <= 2'h0;
      wp_reg <= 1'b0;
      rp_reg <= 1'b0;
      ready_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      ready_reg <= (cnt_next != `ADCR_BUF_FULL);
      if (push)
        wp_reg <= ~wp_reg;
      if (pop)
        rp_reg <= ~rp_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem_reg[wp_reg] <= up.data;
  end

  buf_no_overfill_a: assert property (@(posedge clk) disable iff (reset)
    push |-> cnt_reg != `ADCR_BUF_FULL)
    else $error("sample taken into full buffer");
  buf_stall_hold_a: assert property (@(posedge clk) disable iff (reset)
    dn.valid && !dn.ready |=> dn.valid && $stable(dn.data))
    else $error("stalled sample changed or vanished");
endmodule

/* hw/adcr_regs.sv */
// host register bank of the analog/digital I/O board with sample FIFO
// Operation
// - timer or external source enables on config write
// - software source waits for trigger write
// - byte access allowed at any offset
// - status read shows configuration jumpers
// - sixteen-bit samples through 1K sample FIFO
// - FIFO advances only on high byte read or word read at the result offset
// - each trigger write while the software source is armed issues exactly one start
// - full FIFO pauses conversions until read
`include "adcr_defs.svh"
module adcr_regs #(
  // arbitrary model code
  parameter logic [7:0] MODEL_CODE = 8'h5a
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // host byte/word access
  input wire logic [4:0] host_addr,
  input wire logic host_word,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  output logic host_rvalid,
  // samples from the converter sequencer
  input wire logic sample_valid,
  input wire adcr_pkg::adcr_sample_t sample_data,
  output logic sample_ready,
  input wire logic scan_done_event,
  // converter control
  output logic conv_start,
  output logic conv_enable,
  output logic conv_paused,
  output adcr_pkg::adcr_src_t start_source,
  output logic start_scan,
  output logic start_falling,
  output logic ct0_ext_clk,
  output logic [31:0] gain_cfg,
  output logic [3:0] first_chan,
  output logic [3:0] last_chan,
  output logic [7:0] oversample,
  // counter/timer byte access
  output logic counter_wr,
  output logic [1:0] counter_sel,
  output logic [7:0] counter_wbyte,
  input wire logic [31:0] counter_rdata,
  // analog outputs and interrupt configuration
  output logic [11:0] dac0_value,
  output logic [11:0] dac1_value,
  output logic [7:0] irq_cfg,
  // digital ports
  input wire logic [15:0] dio_in,
  output logic [15:0] dio_out,
  output logic [15:0] dio_oe,
  // nonvolatile, calibration, reset
  input wire logic [7:0] nv_in,
  output logic nv_wr,
  output logic cal_in_wr,
  output logic cal_out_wr,
  output logic [7:0] aux_byte,
  output logic board_reset,
  // jumper straps
  input wire logic [3:0] jumpers
);
  import adcr_pkg::*;

  adcr_sample_t fifo_mem [`ADCR_FIFO_DEPTH];
  logic [9:0] wr_ptr_reg;
  logic [9:0] rd_ptr_reg;
  logic [10:0] fifo_cnt_reg;
  logic fifo_full;
  logic fifo_empty;
  logic push;
  logic pop;
  logic flush;
  adcr_sample_t head;
  logic sw_armed_reg;
  logic simul_reg;
  logic [11:0] dac0_hold_reg;
  logic [7:0] dio_dir_reg;
  logic scan_seen_reg;
  logic [27:0] sync1_reg;
  logic [27:0] sync2_reg;
  logic [7:0] trig_byte;
  logic [7:0] outcfg_byte;

  adcr_stream_if in_s ();
  adcr_stream_if out_s ();

  adcr_skid_buf u_buf (
    .clk (clk),
    .reset (reset),
    .up (in_s.snk),
    .dn (out_s.src)
  );

  assign in_s.valid = sample_valid;
  assign in_s.data = sample_data;
  assign sample_ready = in_s.ready;

  function automatic logic hits(input logic [4:0] off);
    hits = (host_addr == off) || (host_word && host_addr[4:1] == off[4:1]);
  endfunction

  function automatic logic wr_at(input logic [4:0] off);
    wr_at = host_wr && hits(off);
  endfunction

  function automatic logic [7:0] lane(input logic [4:0] off);
    lane = (host_word && off[0]) ? host_wdata[15:8] : host_wdata[7:0];
  endfunction

  // low nibble of a lane, for the 12-bit output upper bytes
  function automatic logic [3:0] lane_lo(input logic [4:0] off);
    logic [7:0] b;
    b = lane(off);
    lane_lo = b[3:0];
  endfunction

  // straps, port pins and nonvolatile data come from outside
  always_ff @(posedge clk)
  begin
    sync1_reg <= {jumpers, nv_in, dio_in};
    sync2_reg <= sync1_reg;
  end

  assign fifo_full = (fifo_cnt_reg == `ADCR_FIFO_FULL);
  assign fifo_empty = (fifo_cnt_reg == 11'h000);
  assign head = fifo_empty ? 16'h0000 : fifo_mem[rd_ptr_reg];
  assign out_s.ready = !fifo_full;
  assign push = out_s.valid && out_s.ready;
  assign flush = wr_at(`ADCR_OFF_BRESET);
  assign pop = host_rd && !fifo_empty
    && ((host_word && host_addr == `ADCR_OFF_RESULT)
    || (!host_word && host_addr == `ADCR_OFF_TRIGGER));
  assign trig_byte = lane(`ADCR_OFF_TRIGCFG);
  assign outcfg_byte = lane(`ADCR_OFF_OUTCFG);

  // sample FIFO
  always_ff @(posedge clk)
  begin
    if (push)
      fifo_mem[wr_ptr_reg] <= out_s.data;
  end

  always_ff @(posedge clk)
  begin
    if (reset || flush)
    begin
      wr_ptr_reg <= 10'h000;
      rd_ptr_reg <= 10'h000;
      fifo_cnt_reg <= 11'h000;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 10'h001;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 10'h001;
      if (push && !pop)
        fifo_cnt_reg <= fifo_cnt_reg + 11'h001;
      else if (pop && !push)
        fifo_cnt_reg <= fifo_cnt_reg - 11'h001;
    end
  end

  // start source and conversion enable
  always_ff @(posedge clk)
  begin
    if (reset || flush)
    begin
      start_source <= ADCR_SRC_SOFT;
      start_scan <= 1'b0;
      start_falling <= 1'b0;
      ct0_ext_clk <= 1'b0;
      conv_enable <= 1'b0;
      sw_armed_reg <= 1'b0;
      conv_start <= 1'b0;
    end
    else
    begin
      conv_start <= 1'b0;
      if (wr_at(`ADCR_OFF_TRIGCFG))
      begin
        start_source <= adcr_src_t'(trig_byte[1:0]);
        start_scan <= trig_byte[`ADCR_BIT_SCAN];
        start_falling <= trig_byte[`ADCR_BIT_FALL];
        ct0_ext_clk <= trig_byte[`ADCR_BIT_CLKSRC];
        conv_enable <= (trig_byte[1:0] == ADCR_SRC_TIMER)
          || (trig_byte[1:0] == ADCR_SRC_EXT);
        sw_armed_reg <= (trig_byte[1:0] == ADCR_SRC_SOFT);
      end
      else if (wr_at(`ADCR_OFF_TRIGGER) && sw_armed_reg)
      begin
        conv_enable <= 1'b1;
        conv_start <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      conv_paused <= 1'b0;
    else
      conv_paused <= fifo_full;
  end

  // configuration bytes; unmatched offsets store nothing
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      gain_cfg <= 32'h0000_0000;
      first_chan <= 4'h0;
      last_chan <= 4'h0;
      oversample <= 8'h00;
      irq_cfg <= 8'h00;
      dio_dir_reg <= 8'h00;
      simul_reg <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
        if (wr_at(`ADCR_OFF_GAIN + 5'(i)))
          gain_cfg[i*8 +: 8] <= lane(`ADCR_OFF_GAIN + 5'(i));
      if (wr_at(`ADCR_OFF_RANGE))
        {last_chan, first_chan} <= lane(`ADCR_OFF_RANGE);
      if (wr_at(`ADCR_OFF_OVERSAMP))
        oversample <= lane(`ADCR_OFF_OVERSAMP);
      if (wr_at(`ADCR_OFF_IRQ))
        irq_cfg <= lane(`ADCR_OFF_IRQ);
      if (wr_at(`ADCR_OFF_DIOCFG))
        dio_dir_reg <= lane(`ADCR_OFF_DIOCFG);
      if (wr_at(`ADCR_OFF_OUTCFG))
        simul_reg <= outcfg_byte[`ADCR_BIT_SIMUL];
    end
  end

  // analog outputs; output 0 held back until an output 1 write while simultaneous update is on
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      dac0_hold_reg <= 12'h000;
      dac0_value <= 12'h000;
      dac1_value <= 12'h000;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
        if (wr_at(`ADCR_OFF_OUT0 + 5'(i)))
        begin
          if (i == 0)
            dac0_hold_reg[7:0] <= lane(`ADCR_OFF_OUT0);
          else
            dac0_hold_reg[11:8] <= lane_lo(`ADCR_OFF_OUT0 + 5'h01);
        end
      if (!simul_reg)
        dac0_value <= dac0_hold_reg;
      if (wr_at(`ADCR_OFF_OUT1))
        dac1_value[7:0] <= lane(`ADCR_OFF_OUT1);
      if (wr_at(`ADCR_OFF_OUT1 + 5'h01))
        dac1_value[11:8] <= lane_lo(`ADCR_OFF_OUT1 + 5'h01);
      if (simul_reg && (wr_at(`ADCR_OFF_OUT1)
          || wr_at(`ADCR_OFF_OUT1 + 5'h01)))
        dac0_value <= dac0_hold_reg;
    end
  end

  // digital ports, pulse strobes and byte hand-offs
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      dio_out <= 16'h0000;
      dio_oe <= 16'h0000;
      counter_wr <= 1'b0;
      counter_sel <= 2'h0;
      counter_wbyte <= 8'h00;
      nv_wr <= 1'b0;
      cal_in_wr <= 1'b0;
      cal_out_wr <= 1'b0;
      aux_byte <= 8'h00;
      board_reset <= 1'b0;
    end
    else
    begin
      if (wr_at(`ADCR_OFF_PORTLO))
        dio_out[7:0] <= lane(`ADCR_OFF_PORTLO);
      if (wr_at(`ADCR_OFF_PORTHI))
        dio_out[15:8] <= lane(`ADCR_OFF_PORTHI);
      dio_oe <= {{8{dio_dir_reg[`ADCR_BIT_DIR_HI]}},
                 {8{dio_dir_reg[`ADCR_BIT_DIR_LO]}}};
      counter_wr <= 1'b0;
      // descending, so a word write hands over its lower byte
      for (int i = 3; i >= 0; i--)
        if (wr_at(`ADCR_OFF_COUNTER + 5'(i)))
        begin
          counter_wr <= 1'b1;
          counter_sel <= 2'(i);
          counter_wbyte <= lane(`ADCR_OFF_COUNTER + 5'(i));
        end
      nv_wr <= wr_at(`ADCR_OFF_NV);
      cal_in_wr <= wr_at(`ADCR_OFF_CALIN);
      cal_out_wr <= wr_at(`ADCR_OFF_CALOUT);
      if (wr_at(`ADCR_OFF_NV))
        aux_byte <= lane(`ADCR_OFF_NV);
      else if (wr_at(`ADCR_OFF_CALIN))
        aux_byte <= lane(`ADCR_OFF_CALIN);
      else if (wr_at(`ADCR_OFF_CALOUT))
        aux_byte <= lane(`ADCR_OFF_CALOUT);
      board_reset <= flush;
    end
  end

  // end-of-scan seen flag, cleared by reading the interrupt byte
  always_ff @(posedge clk)
  begin
    if (reset)
      scan_seen_reg <= 1'b0;
    else if (scan_done_event)
      scan_seen_reg <= 1'b1;
    else if (host_rd && hits(`ADCR_OFF_IRQ))
      scan_seen_reg <= 1'b0;
  end

  function automatic logic [7:0] rd_byte(input logic [4:0] off);
    case (off)
      `ADCR_OFF_RESULT: rd_byte = head[7:0];
      `ADCR_OFF_TRIGGER: rd_byte = head[15:8];
      `ADCR_OFF_COUNTER: rd_byte = counter_rdata[7:0];
      `ADCR_OFF_COUNTER + 5'h01: rd_byte = counter_rdata[15:8];
      `ADCR_OFF_COUNTER + 5'h02: rd_byte = counter_rdata[23:16];
      `ADCR_OFF_COUNTER + 5'h03: rd_byte = counter_rdata[31:24];
      `ADCR_OFF_STATUS: rd_byte = {sync2_reg[27:24], conv_enable, fifo_full,
        fifo_cnt_reg >= `ADCR_FIFO_HALF, !fifo_empty};
      `ADCR_OFF_IRQ: rd_byte = {5'h00, scan_seen_reg, fifo_full,
        fifo_cnt_reg >= `ADCR_FIFO_HALF};
      `ADCR_OFF_PORTLO: rd_byte = dio_oe[0] ? dio_out[7:0] : sync2_reg[7:0];
      `ADCR_OFF_PORTHI: rd_byte = dio_oe[8] ? dio_out[15:8] : sync2_reg[15:8];
      `ADCR_OFF_NV: rd_byte = sync2_reg[23:16];
      `ADCR_OFF_MODEL: rd_byte = MODEL_CODE;
      default: rd_byte = `ADCR_UNMAPPED;
    endcase
  endfunction

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      host_rdata <= 16'h0000;
      host_rvalid <= 1'b0;
    end
    else
    begin
      host_rvalid <= host_rd;
      if (host_rd && host_word)
        host_rdata <= {rd_byte({host_addr[4:1], 1'b1}),
                       rd_byte({host_addr[4:1], 1'b0})};
      else if (host_rd)
        host_rdata <= {8'h00, rd_byte(host_addr)};
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sw_start_pulse_a: assert property (
    wr_at(`ADCR_OFF_TRIGGER) && sw_armed_reg && !flush
    && !wr_at(`ADCR_OFF_TRIGCFG) |=> conv_start ##1 !conv_start)
    else $error("trigger write did not give one start pulse");
  start_needs_arm_a: assert property (
    conv_start |-> $past(sw_armed_reg) && start_source == ADCR_SRC_SOFT)
    else $error("start pulse without software arming");
  cfg_enable_a: assert property (
    wr_at(`ADCR_OFF_TRIGCFG) && !flush
    && (trig_byte[1:0] == 2'h1 || trig_byte[1:0] == 2'h2)
    |=> conv_enable)
    else $error("timer or external source not enabled");
  full_pause_a: assert property (
    fifo_full |-> !out_s.ready ##1 conv_paused)
    else $error("full FIFO did not pause");
  low_byte_hold_a: assert property (
    host_rd && !host_word && host_addr == `ADCR_OFF_RESULT && !flush
    |=> $stable(rd_ptr_reg))
    else $error("low byte read advanced the FIFO");
  word_pop_a: assert property (
    pop && !flush |=> rd_ptr_reg == $past(rd_ptr_reg) + 10'h001)
    else $error("result read did not advance the FIFO");
  unmapped_read_a: assert property (
    host_rd && !host_word && host_addr == `ADCR_OFF_SPARE
    |=> host_rvalid && host_rdata == 16'h0000)
    else $error("unmapped read not zero");
  jumper_status_a: assert property (
    host_rd && !host_word && host_addr == `ADCR_OFF_STATUS
    |=> host_rdata[7:4] == $past(sync2_reg[27:24]))
    else $error("status does not show jumpers");
  fifo_bound_a: assert property (
    fifo_cnt_reg <= `ADCR_FIFO_FULL)
    else $error("FIFO count past depth");
endmodule

/* test/adcr_conv_model.sv */
// converter sequencer stand-in that feeds the sample stream
module adcr_conv_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control from the bank
  input wire logic conv_start,
  input wire logic conv_enable,
  input wire logic burst,
  // sample stream
  input wire logic sample_ready,
  output logic sample_valid,
  output logic [15:0] sample_data
);
  timeunit 1ns;
  timeprecision 1ns;
  int pend;
  logic busy;
  logic [15:0] word_reg;
  // one sample per start, or a stream while free running
  always @(posedge clk)
  begin
    if (conv_start)
      pend = pend + 1;
    busy = sample_valid && !sample_ready;
    if (sample_valid && sample_ready)
      word_reg = word_reg + 16'h0001;
    if (reset)
    begin
      pend = 0;
      word_reg = 16'h1234;
      sample_valid <= 1'b0;
      sample_data <= 16'hffff;
    end
    else if (!busy && (pend > 0 || (burst && conv_enable)))
    begin
      sample_valid <= 1'b1;
      sample_data <= word_reg;
      if (pend > 0)
        pend = pend - 1;
    end
    else if (!busy)
    begin
      sample_valid <= 1'b0;
      sample_data <= ~word_reg;
    end
  end
endmodule

/* test/adcr_regs_tb.sv */
// self-checking bench for the host register bank
module adcr_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] MODEL = 8'h3c; // arbitrary model code
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] host_addr = 5'h00;
  logic host_word = 1'b0;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  logic [15:0] host_wdata = 16'h0000;
  logic [15:0] host_rdata;
  logic host_rvalid;
  logic sample_valid;
  logic sample_ready;
  logic [15:0] sample_data;
  logic burst = 1'b0;
  logic [3:0] jumpers = 4'h0;
  logic scan_done = 1'b0;
  logic counter_wr, board_reset, nv_wr;
  logic [1:0] counter_sel;
  logic [7:0] counter_wbyte, aux_byte;
  logic [15:0] dio_out, dio_oe;
  logic conv_start, conv_enable, conv_paused;
  logic start_scan, start_falling, ct0_ext_clk;
  adcr_pkg::adcr_src_t start_source;
  logic [31:0] gain_cfg;
  logic [3:0] first_chan, last_chan;
  logic [7:0] oversample;
  logic [11:0] dac0_value, dac1_value;
  int bad_count = 0;
  int checks_done = 0;

  always #20 clk = ~clk;

  adcr_regs #(.MODEL_CODE(MODEL)) u_dut (.clk(clk), .reset(reset),
    .host_addr(host_addr), .host_word(host_word), .host_wr(host_wr),
    .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .sample_valid(sample_valid),
    .sample_data(sample_data), .sample_ready(sample_ready),
    .scan_done_event(scan_done), .conv_start(conv_start),
    .conv_enable(conv_enable), .conv_paused(conv_paused),
    .start_source(start_source), .start_scan(start_scan),
    .start_falling(start_falling), .ct0_ext_clk(ct0_ext_clk),
    .gain_cfg(gain_cfg), .first_chan(first_chan), .last_chan(last_chan),
    .oversample(oversample), .counter_wr(counter_wr),
    .counter_sel(counter_sel), .counter_wbyte(counter_wbyte),
    .counter_rdata(32'h0000_0000),
    .dac0_value(dac0_value), .dac1_value(dac1_value), .irq_cfg(),
    .dio_in(16'h0000), .dio_out(dio_out), .dio_oe(dio_oe),
    .nv_in(8'h00), .nv_wr(nv_wr),
    .cal_in_wr(), .cal_out_wr(), .aux_byte(aux_byte),
    .board_reset(board_reset), .jumpers(jumpers));

  adcr_conv_model u_conv (.clk(clk), .reset(reset),
    .conv_start(conv_start), .conv_enable(conv_enable), .burst(burst),
    .sample_ready(sample_ready), .sample_valid(sample_valid),
    .sample_data(sample_data));

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic hwr(input logic [4:0] a, input logic w,
    input logic [15:0] d);
    @(posedge clk);
    host_addr <= a;
    host_word <= w;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge clk);
    host_wr <= 1'b0;
  endtask

  task automatic hrd(input logic [4:0] a, input logic w,
    output logic [15:0] d);
    int i;
    @(posedge clk);
    host_addr <= a;
    host_word <= w;
    host_rd <= 1'b1;
    @(posedge clk);
    host_rd <= 1'b0;
    #1;
    for (i = 0; i < 4 && host_rvalid !== 1'b1; i++)
      @(posedge clk) #1;
    if (host_rvalid !== 1'b1)
    begin
      bad_count++;
      end_of_test;
    end
    d = host_rdata;
  endtask

  task automatic rdchk(input logic [4:0] a, input logic w,
    input logic [15:0] exp);
    logic [15:0] d;
    hrd(a, w, d);
    chk(d, exp);
  endtask

  task automatic t_soft;
    hwr(5'h01, 1'b0, 16'h0055);
    #1;
    chk(conv_start, 1'b0);
    hwr(5'h11, 1'b0, 16'h0000);
    #1;
    chk({conv_enable, start_source}, 3'b000);
    hwr(5'h01, 1'b0, 16'h00a7);
    #1;
    chk({conv_start, conv_enable}, 2'b11);
    @(posedge clk) #1;
    chk(conv_start, 1'b0);
    $display("test soft start done");
  endtask

  task automatic t_fifo;
    repeat (3) @(posedge clk);
    rdchk(5'h12, 1'b0, 16'h0009);
    rdchk(5'h00, 1'b0, 16'h0034);
    rdchk(5'h00, 1'b0, 16'h0034);
    rdchk(5'h01, 1'b0, 16'h0012);
    rdchk(5'h00, 1'b1, 16'h0000);
    hwr(5'h01, 1'b0, 16'h0000);
    hwr(5'h01, 1'b0, 16'hffff);
    repeat (4) @(posedge clk);
    rdchk(5'h00, 1'b1, 16'h1235);
    rdchk(5'h01, 1'b0, 16'h0012);
    rdchk(5'h00, 1'b0, 16'h0000);
    $display("test fifo pairing done");
  endtask

  task automatic t_timer;
    hwr(5'h11, 1'b0, 16'h001e);
    #1;
    chk({conv_enable, start_source}, 3'b110);
    chk({ct0_ext_clk, start_falling, start_scan}, 3'b111);
    hwr(5'h1b, 1'b0, 16'h0001);
    #1;
    chk(board_reset, 1'b1);
    repeat (3) @(posedge clk) #1;
    chk(conv_enable, 1'b0);
    hwr(5'h11, 1'b0, 16'h0001);
    #1;
    chk({conv_enable, start_source}, 3'b101);
    $display("test timer start done");
  endtask

  task automatic t_regs;
    hwr(5'h06, 1'b1, 16'h3c21);
    #1;
    chk({oversample, last_chan, first_chan}, 16'h3c21);
    hwr(5'h07, 1'b0, 16'h005e);
    #1;
    chk({oversample, last_chan, first_chan}, 16'h5e21);
    hwr(5'h02, 1'b1, 16'hb4a5);
    hwr(5'h04, 1'b1, 16'h0f1e);
    hwr(5'h05, 1'b0, 16'h0077);
    #1;
    chk(gain_cfg, 32'h771e_b4a5);
    hwr(5'h0c, 1'b1, 16'h0abc);
    hwr(5'h0e, 1'b1, 16'h0123);
    repeat (2) @(posedge clk) #1;
    chk({dac1_value, dac0_value}, 24'h123a_bc);
    hwr(5'h10, 1'b0, 16'h0001);
    hwr(5'h0c, 1'b1, 16'h0456);
    repeat (2) @(posedge clk) #1;
    chk(dac0_value, 12'habc);
    hwr(5'h0e, 1'b1, 16'h0789);
    repeat (2) @(posedge clk) #1;
    chk({dac1_value, dac0_value}, 24'h78_9456);
    hwr(5'h10, 1'b0, 16'h0000);
    hwr(5'h1c, 1'b1, 16'hffff);
    rdchk(5'h1c, 1'b0, 16'h0000);
    rdchk(5'h16, 1'b0, 16'h0000);
    rdchk(5'h1f, 1'b0, {8'h00, MODEL});
    $display("test register decode done");
  endtask

  task automatic t_jump;
    @(posedge clk);
    jumpers <= 4'h9;
    repeat (4) @(posedge clk);
    rdchk(5'h12, 1'b0, 16'h0098);
    $display("test jumpers done");
  endtask

  task automatic t_full;
    int i;
    logic [15:0] d;
    logic [15:0] exp;
    hwr(5'h02, 1'b1, 16'h0000);
    hwr(5'h06, 1'b0, 16'h00f0);
    hwr(5'h07, 1'b0, 16'h0000);
    hwr(5'h08, 1'b0, 16'h0010);
    hwr(5'h11, 1'b0, 16'h0001);
    burst <= 1'b1;
    for (i = 0; i < 1300 && conv_paused !== 1'b1; i++)
      @(posedge clk) #1;
    chk(conv_paused, 1'b1);
    repeat (4) @(posedge clk) #1;
    chk(sample_ready, 1'b0);
    rdchk(5'h12, 1'b0, 16'h009f);
    burst <= 1'b0;
    rdchk(5'h00, 1'b1, 16'h1237);
    for (i = 0; i < 6 && conv_paused !== 1'b0; i++)
      @(posedge clk) #1;
    chk(conv_paused, 1'b0);
    exp = 16'h1238;
    for (i = 0; i < 1100; i++)
    begin
      hrd(5'h00, 1'b1, d);
      if (d === 16'h0000)
        break;
      chk(d, exp);
      exp = exp + 16'h0001;
    end
    chk(exp, 16'h163a);
    rdchk(5'h12, 1'b0, 16'h0098);
    $display("test fifo full done");
  endtask

  task automatic t_misc;
    hwr(5'h0a, 1'b1, 16'h5aa5);
    #1;
    chk({counter_wr, counter_sel, counter_wbyte}, {1'b1, 2'h2, 8'ha5});
    @(posedge clk) #1;
    chk(counter_wr, 1'b0);
    hwr(5'h17, 1'b0, 16'h0001);
    hwr(5'h14, 1'b1, 16'h3ca5);
    #1;
    chk({dio_oe, dio_out}, 32'h00ff_3ca5);
    rdchk(5'h14, 1'b0, 16'h00a5);
    rdchk(5'h15, 1'b0, 16'h0000);
    hwr(5'h18, 1'b0, 16'h0066);
    #1;
    chk({nv_wr, aux_byte}, {1'b1, 8'h66});
    @(posedge clk);
    scan_done <= 1'b1;
    @(posedge clk);
    scan_done <= 1'b0;
    rdchk(5'h13, 1'b0, 16'h0004);
    rdchk(5'h13, 1'b0, 16'h0000);
    $display("test side strobes done");
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_soft;
    t_fifo;
    t_timer;
    t_regs;
    t_jump;
    t_full;
    t_misc;
    end_of_test;
  end
endmodule
